// ### common/pft_pkg.sv
package pft_pkg;

   // clock and fine time base
   localparam int CLK_FREQ_MHZ = 50;
   localparam int CLK_PERIOD_PS = 1000000 / CLK_FREQ_MHZ;
   localparam real TICK_US = 0.0032;
   localparam int TICK_PS = 3200;
   // counters run in quarter ticks so that one clock advances a whole number of them
   localparam int QTR_PER_TICK = 4;
   localparam int ACC_W = 38;
   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_PS * QTR_PER_TICK / TICK_PS);

   // channel counts
   localparam int NUM_GEN = 4;
   localparam int GEN_IDX_W = 2;
   localparam int NUM_LINK = 2;
   localparam int NUM_GPI = 8;
   localparam int NUM_FRONT_IN = 4;
   localparam int NUM_BYPASS = NUM_GPI + NUM_FRONT_IN;
   localparam int NUM_GPO = 8;
   localparam int NUM_FRONT_OUT = 2;

   // decimation settings
   localparam int FACTOR_W = 3;
   localparam int SLOT_W = 3;
   localparam logic [FACTOR_W-1:0] FACTOR_MIN = 3'h1;
   localparam logic [FACTOR_W-1:0] FACTOR_RST = 3'h1;
   localparam logic [SLOT_W-1:0] SLOT_MAX = 3'h6;
   localparam logic [SLOT_W-1:0] SLOT_RST = 3'h0;

   // delay and width in time base steps
   localparam int DELAY_W = 34;
   localparam int WIDTH_W = 35;
   localparam real DELAY_MAX_US = 3.4E7;
   localparam real DELAY_RST_US = 0.0;
   localparam real WIDTH_MAX_US = 6.8E7;
   localparam real WIDTH_MIN_US = 0.0032;
   localparam real WIDTH_RST_US = 4.0;
   localparam logic [DELAY_W-1:0] DELAY_MAX = DELAY_W'(longint'(DELAY_MAX_US / TICK_US));
   localparam logic [DELAY_W-1:0] DELAY_RST = DELAY_W'(longint'(DELAY_RST_US / TICK_US));
   localparam logic [WIDTH_W-1:0] WIDTH_MAX = WIDTH_W'(longint'(WIDTH_MAX_US / TICK_US));
   localparam logic [WIDTH_W-1:0] WIDTH_MIN = WIDTH_W'(longint'(WIDTH_MIN_US / TICK_US));
   localparam logic [WIDTH_W-1:0] WIDTH_RST = WIDTH_W'(longint'(WIDTH_RST_US / TICK_US));

   // register map
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] GEN_AREA_END = 12'h080;
   localparam int GEN_IDX_LSB = 5;
   localparam logic [ADDR_W-1:0] GEN_OFF_MASK = 12'h01F;
   localparam logic [ADDR_W-1:0] OFF_GEN_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_DELAY_LO = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_DELAY_HI = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_WIDTH_LO = 12'h00C;
   localparam logic [ADDR_W-1:0] OFF_WIDTH_HI = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_GEN_STAT = 12'h014;
   localparam logic [ADDR_W-1:0] ADDR_LINK0_SRC = 12'h080;
   localparam logic [ADDR_W-1:0] ADDR_LINK1_SRC = 12'h084;
   localparam logic [ADDR_W-1:0] ADDR_GPO_OUT = 12'h088;

   // field positions
   localparam int CTRL_FACTOR_LSB = 0;
   localparam int CTRL_SLOT_LSB = 4;
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_POS_LSB = 4;
   localparam int GPO_FRONT_LSB = 8;

   // link trigger source codes
   localparam int SRC_W = 6;
   localparam logic [SRC_W-1:0] SRC_GND = 6'h00;
   localparam int SRC_GEN_START = 1;
   localparam int SRC_GEN_END = SRC_GEN_START + NUM_GEN;
   localparam int SRC_BYPASS = SRC_GEN_END + NUM_GEN;
   localparam int SRC_COUNT = SRC_BYPASS + 2 * NUM_BYPASS;
   localparam logic [SRC_W-1:0] LINK0_SRC_RST = 6'h01;
   localparam logic [SRC_W-1:0] LINK1_SRC_RST = 6'h00;

   typedef struct packed {
      logic [FACTOR_W-1:0] factor;
      logic [SLOT_W-1:0] slot;
      logic [DELAY_W-1:0] delay;
      logic [WIDTH_W-1:0] width;
   } pft_gen_cfg_t;

   typedef struct packed {
      logic active;
      logic busy;
      logic [FACTOR_W-1:0] pos;
   } pft_gen_stat_t;

   typedef enum logic [1:0] {
      GEN_IDLE,
      GEN_DELAY,
      GEN_ACTIVE
   } pft_gen_state_t;

endpackage : pft_pkg

// ### rtl/pft_pulse_gen.sv
`timescale 1ns/1ps
module pft_pulse_gen
   import pft_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration
   input pft_gen_cfg_t cfg,
   input wire logic cfg_restart,
   // trigger edge in
   input wire logic trig_edge,
   // pulse out
   output logic pulse_out,
   output logic start_pulse,
   output logic end_pulse,
   output pft_gen_stat_t stat
);

   pft_gen_state_t state_q;
   logic [FACTOR_W-1:0] pos_q;
   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] acc_d;
   logic [ACC_W-1:0] delay_target;
   logic [ACC_W-1:0] width_target;
   logic forward;
   logic last_pos;

   assign acc_d = acc_q + ACC_STEP;
   assign delay_target = {2'b00, cfg.delay, 2'b00}; // RULE16
   assign width_target = {1'b0, cfg.width, 2'b00}; // RULE16
   // a slot at or above the factor is never reached, so nothing is forwarded
   assign forward = trig_edge && (pos_q == cfg.slot); // RULE2 RULE3
   assign last_pos = (FACTOR_W'(pos_q + 3'h1) >= cfg.factor);

   ////////////////////////////////////////////////////////////////////////////
   // decimation group position
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pos_q <= '0;
      end else if (cfg_restart) begin
         pos_q <= '0; // RULE17
      end else if (trig_edge) begin
         pos_q <= last_pos ? '0 : FACTOR_W'(pos_q + 3'h1); // RULE1
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // delay and active phases; a forwarded trigger while busy is dropped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= GEN_IDLE;
         acc_q <= '0;
         pulse_out <= 1'b0;
         start_pulse <= 1'b0;
         end_pulse <= 1'b0;
      end else begin
         start_pulse <= 1'b0;
         end_pulse <= 1'b0;
         case (state_q)
            GEN_IDLE: begin
               acc_q <= '0;
               if (forward) begin
                  if (cfg.delay == '0) begin
                     state_q <= GEN_ACTIVE;
                     pulse_out <= 1'b1;
                     start_pulse <= 1'b1;
                  end else begin
                     state_q <= GEN_DELAY; // RULE5
                  end
               end
            end
            GEN_DELAY: begin
               if (acc_d >= delay_target) begin
                  state_q <= GEN_ACTIVE; // RULE5
                  acc_q <= '0;
                  pulse_out <= 1'b1;
                  start_pulse <= 1'b1;
               end else begin
                  acc_q <= acc_d;
               end
            end
            GEN_ACTIVE: begin
               if (acc_d >= width_target) begin
                  state_q <= GEN_IDLE; // RULE6
                  acc_q <= '0;
                  pulse_out <= 1'b0;
                  end_pulse <= 1'b1;
               end else begin
                  acc_q <= acc_d;
               end
            end
            default: begin
               state_q <= GEN_IDLE;
               acc_q <= '0;
               pulse_out <= 1'b0;
            end
         endcase
      end
   end

   assign stat.active = pulse_out;
   assign stat.busy = (state_q != GEN_IDLE);
   assign stat.pos = pos_q;

endmodule : pft_pulse_gen

// ### rtl/pft_trigger_mapper.sv
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
// Function
// [RULE1] each generator passes one of every N trigger pulses, dropping N minus one
// [RULE2] slot picks the group position forwarded; slot zero forwards the first pulse
// [RULE3] software keeps the decimation factor above the slot of the same generator
// [RULE4] slot setting takes 0 to 6 in steps of one, 0 after reset
// [RULE5] output pulse delayed 0 to 3.4E7 us in 0.0032 us steps, default zero
// [RULE6] output active width 0.0032 to 6.8E7 us in 0.0032 us steps, default 4.0 us
// [RULE7] four generators with identical independent factor, slot, delay, width settings
// [RULE8] a link trigger may take the start or end of any generator pulse
// [RULE9] a link trigger sourced from ground emits no events
// [RULE10] exposure-timed camera: software routes only pulse start, normally on channel 0
// [RULE11] edge-pair exposure: software puts start on channel 0, end on channel 1
// [RULE12] only input edges are used; input pulse length is not passed on
// [RULE13] bypass forwards a chosen input's rising or falling edge straight to a link trigger
// [RULE14] eight general purpose outputs plus two front-panel outputs toward the camera
// [RULE15] decimation factor takes 1 to 7, default 1, where 1 forwards every pulse
// [RULE16] delay and width count 3.2 ns steps; output on from delay end to width end
// [RULE17] group position restarts whenever factor or slot is written
module pft_trigger_mapper
   import pft_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // trigger pulses from the trigger system
   input wire logic trig_pulse,
   // bypass inputs
   input wire logic [NUM_GPI-1:0] gpi,
   input wire logic [NUM_FRONT_IN-1:0] front_gpi,
   // generator outputs
   output logic [NUM_GEN-1:0] gen_pulse,
   // camera side
   output logic [NUM_LINK-1:0] link_trigger,
   output logic [NUM_GPO-1:0] gpo,
   output logic [NUM_FRONT_OUT-1:0] front_panel_outputs
);

   logic [FACTOR_W-1:0] factor_q [NUM_GEN];
   logic [SLOT_W-1:0] decimation_slot_select_q [NUM_GEN];
   logic [DELAY_W-1:0] pulse_delay_time_q [NUM_GEN];
   logic [WIDTH_W-1:0] pulse_active_time_q [NUM_GEN];
   logic [NUM_GEN-1:0] cfg_restart_q;
   pft_gen_cfg_t gen_cfg [NUM_GEN];
   pft_gen_stat_t gen_stat [NUM_GEN];
   logic [NUM_GEN-1:0] gen_start;
   logic [NUM_GEN-1:0] gen_end;
   logic [SRC_W-1:0] link_src_q [NUM_LINK];
   logic [NUM_GPO+NUM_FRONT_OUT-1:0] gpo_q;
   logic trig_prev_q;
   logic trig_edge;
   logic [NUM_BYPASS-1:0] byp_prev_q;
   logic [NUM_BYPASS-1:0] byp_now;
   logic [NUM_BYPASS-1:0] byp_rise;
   logic [NUM_BYPASS-1:0] byp_fall;
   logic [SRC_COUNT-1:0] event_vec;
   logic [NUM_LINK-1:0] link_trigger_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_data;
   logic rd_hit;
   logic wr_en;
   logic setup;
   logic [GEN_IDX_W-1:0] acc_gen;
   logic [ADDR_W-1:0] acc_off;
   logic in_gen_area;
   logic [31:0] wmask;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite;
   assign acc_gen = paddr[GEN_IDX_LSB +: GEN_IDX_W];
   assign acc_off = paddr & GEN_OFF_MASK;
   assign in_gen_area = (paddr < GEN_AREA_END);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !rd_hit;
   assign prdata = prdata_q;

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[8*b +: 8] = pstrb[b] ? 8'hFF : 8'h00;
      end
   end

   // read mux; also marks which addresses are mapped
   always_comb begin
      rd_data = '0;
      rd_hit = 1'b0;
      if (paddr[1:0] == 2'b00) begin
         if (in_gen_area) begin
            case (acc_off)
               OFF_GEN_CTRL: begin
                  rd_hit = 1'b1;
                  rd_data[CTRL_FACTOR_LSB +: FACTOR_W] = factor_q[acc_gen];
                  rd_data[CTRL_SLOT_LSB +: SLOT_W] = decimation_slot_select_q[acc_gen];
               end
               OFF_DELAY_LO: begin
                  rd_hit = 1'b1;
                  rd_data = pulse_delay_time_q[acc_gen][31:0];
               end
               OFF_DELAY_HI: begin
                  rd_hit = 1'b1;
                  rd_data[DELAY_W-33:0] = pulse_delay_time_q[acc_gen][DELAY_W-1:32];
               end
               OFF_WIDTH_LO: begin
                  rd_hit = 1'b1;
                  rd_data = pulse_active_time_q[acc_gen][31:0];
               end
               OFF_WIDTH_HI: begin
                  rd_hit = 1'b1;
                  rd_data[WIDTH_W-33:0] = pulse_active_time_q[acc_gen][WIDTH_W-1:32];
               end
               OFF_GEN_STAT: begin
                  rd_hit = 1'b1;
                  rd_data[STAT_ACTIVE_BIT] = gen_stat[acc_gen].active;
                  rd_data[STAT_BUSY_BIT] = gen_stat[acc_gen].busy;
                  rd_data[STAT_POS_LSB +: FACTOR_W] = gen_stat[acc_gen].pos;
               end
               default: begin
                  rd_hit = 1'b0;
               end
            endcase
         end else begin
            case (paddr)
               ADDR_LINK0_SRC: begin
                  rd_hit = 1'b1;
                  rd_data[SRC_W-1:0] = link_src_q[0];
               end
               ADDR_LINK1_SRC: begin
                  rd_hit = 1'b1;
                  rd_data[SRC_W-1:0] = link_src_q[1];
               end
               ADDR_GPO_OUT: begin
                  rd_hit = 1'b1;
                  rd_data[NUM_GPO+NUM_FRONT_OUT-1:0] = gpo_q;
               end
               default: begin
                  rd_hit = 1'b0;
               end
            endcase
         end
      end
   end

   // read data captured in the setup cycle so it stands through the access cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_q <= '0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per generator settings and instances
   for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
      logic sel_here;
      logic [31:0] ctrl_new;
      logic [FACTOR_W-1:0] fac_wr;
      logic [SLOT_W-1:0] slot_wr;

      assign sel_here = wr_en && in_gen_area && (acc_gen == GEN_IDX_W'(g))
                        && (paddr[1:0] == 2'b00);
      assign ctrl_new = pwdata & wmask;
      assign fac_wr = ctrl_new[CTRL_FACTOR_LSB +: FACTOR_W];
      assign slot_wr = ctrl_new[CTRL_SLOT_LSB +: SLOT_W];

      // decimation settings, clamped into their legal ranges
      always_ff @(posedge clk or posedge rst) begin // RULE7
         if (rst) begin
            factor_q[g] <= FACTOR_RST; // RULE15
            decimation_slot_select_q[g] <= SLOT_RST; // RULE4
            cfg_restart_q[g] <= 1'b0;
         end else begin
            cfg_restart_q[g] <= 1'b0;
            if (sel_here && (acc_off == OFF_GEN_CTRL) && pstrb[0]) begin
               factor_q[g] <= (fac_wr < FACTOR_MIN) ? FACTOR_MIN : fac_wr; // RULE15
               decimation_slot_select_q[g] <= (slot_wr > SLOT_MAX) ? SLOT_MAX : slot_wr; // RULE4
               cfg_restart_q[g] <= 1'b1; // RULE17
            end
         end
      end

      // delay and width step counts, split over low and high words
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            pulse_delay_time_q[g] <= DELAY_RST; // RULE5
            pulse_active_time_q[g] <= WIDTH_RST; // RULE6
         end else if (sel_here) begin
            case (acc_off)
               OFF_DELAY_LO: begin
                  pulse_delay_time_q[g][31:0] <= (pulse_delay_time_q[g][31:0] & ~wmask)
                                                 | (pwdata & wmask);
               end
               OFF_DELAY_HI: begin
                  if (pstrb[0]) begin
                     pulse_delay_time_q[g][DELAY_W-1:32] <= pwdata[DELAY_W-33:0];
                  end
               end
               OFF_WIDTH_LO: begin
                  pulse_active_time_q[g][31:0] <= (pulse_active_time_q[g][31:0] & ~wmask)
                                                  | (pwdata & wmask);
               end
               OFF_WIDTH_HI: begin
                  if (pstrb[0]) begin
                     pulse_active_time_q[g][WIDTH_W-1:32] <= pwdata[WIDTH_W-33:0];
                  end
               end
               default: begin
               end
            endcase
         end
      end

      // limits applied on use so the two halves may be written in any order
      always_comb begin
         gen_cfg[g].factor = factor_q[g];
         gen_cfg[g].slot = decimation_slot_select_q[g];
         gen_cfg[g].delay = (pulse_delay_time_q[g] > DELAY_MAX) ? DELAY_MAX
                            : pulse_delay_time_q[g]; // RULE5
         if (pulse_active_time_q[g] < WIDTH_MIN) begin
            gen_cfg[g].width = WIDTH_MIN; // RULE6
         end else if (pulse_active_time_q[g] > WIDTH_MAX) begin
            gen_cfg[g].width = WIDTH_MAX; // RULE6
         end else begin
            gen_cfg[g].width = pulse_active_time_q[g];
         end
      end

      pft_pulse_gen u_gen (
         .clk(clk),
         .rst(rst),
         .cfg(gen_cfg[g]),
         .cfg_restart(cfg_restart_q[g]),
         .trig_edge(trig_edge),
         .pulse_out(gen_pulse[g]),
         .start_pulse(gen_start[g]),
         .end_pulse(gen_end[g]),
         .stat(gen_stat[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge detection of trigger and bypass inputs
   assign byp_now = {front_gpi, gpi};
   assign trig_edge = trig_pulse && !trig_prev_q; // RULE12
   assign byp_rise = byp_now & ~byp_prev_q; // RULE12
   assign byp_fall = ~byp_now & byp_prev_q; // RULE12

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trig_prev_q <= 1'b0;
         byp_prev_q <= '0;
      end else begin
         trig_prev_q <= trig_pulse;
         byp_prev_q <= byp_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link trigger source selection
   always_comb begin
      event_vec = '0;
      event_vec[SRC_GEN_START +: NUM_GEN] = gen_start; // RULE8
      event_vec[SRC_GEN_END +: NUM_GEN] = gen_end; // RULE8
      for (int k = 0; k < NUM_BYPASS; k++) begin
         event_vec[SRC_BYPASS + 2*k] = byp_rise[k]; // RULE13
         event_vec[SRC_BYPASS + 2*k + 1] = byp_fall[k]; // RULE13
      end
   end

   for (genvar c = 0; c < NUM_LINK; c++) begin : g_link
      logic sel_src;

      assign sel_src = wr_en && pstrb[0]
                       && (paddr == ((c == 0) ? ADDR_LINK0_SRC : ADDR_LINK1_SRC));

      // unknown codes fall back to ground
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            link_src_q[c] <= (c == 0) ? LINK0_SRC_RST : LINK1_SRC_RST;
         end else if (sel_src) begin
            link_src_q[c] <= (pwdata[SRC_W-1:0] < SRC_W'(SRC_COUNT)) ? pwdata[SRC_W-1:0]
                             : SRC_GND;
         end
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            link_trigger_q[c] <= 1'b0;
         end else if (link_src_q[c] == SRC_GND) begin
            link_trigger_q[c] <= 1'b0; // RULE9
         end else begin
            link_trigger_q[c] <= event_vec[link_src_q[c]]; // RULE8 RULE13
         end
      end
   end

   assign link_trigger = link_trigger_q;

   ////////////////////////////////////////////////////////////////////////////
   // general purpose and front-panel outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gpo_q <= '0;
      end else if (wr_en && (paddr == ADDR_GPO_OUT)) begin
         for (int b = 0; b < NUM_GPO + NUM_FRONT_OUT; b++) begin
            if (pstrb[b/8]) begin
               gpo_q[b] <= pwdata[b]; // RULE14
            end
         end
      end
   end

   assign gpo = gpo_q[NUM_GPO-1:0]; // RULE14
   assign front_panel_outputs = gpo_q[GPO_FRONT_LSB +: NUM_FRONT_OUT]; // RULE14

endmodule : pft_trigger_mapper

// ### verification/pft_trigger_mapper_properties.sv
`timescale 1ns/1ps
module pft_trigger_mapper_chk
   import pft_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // outputs
   input wire logic [NUM_GEN-1:0] gen_pulse,
   input wire logic [NUM_LINK-1:0] link_trigger,
   input wire logic [NUM_GPO-1:0] gpo,
   input wire logic [NUM_FRONT_OUT-1:0] front_panel_outputs
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire acc = psel && penable;
   ////////////////////////////////////////////////////////////
   ready_always_a: assert property (pready) else $error("pready low");
   err_in_access_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
   unaligned_err_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access not refused");
   unmapped_err_a: assert property (acc && paddr >= 12'h08C |-> pslverr)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (acc && paddr < 12'h08C && paddr[1:0] == 2'h0
      && paddr[4:0] <= 5'h14 |-> !pslverr) else $error("mapped access refused");
   err_read_zero_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
      else $error("refused read returns data");
   rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable))
      else $error("read data moved outside setup");
   gpo_cause_a: assert property ($changed({gpo, front_panel_outputs}) |->
      $past(acc && pwrite) || $past(acc && pwrite, 2)) else $error("outputs moved unwritten");
   link_event_a: assert property (link_trigger[0] |=> !link_trigger[0])
      else $error("link trigger longer than one cycle");
   gen_seen_c: cover property ($rose(gen_pulse[0]));
   link_seen_c: cover property ($rose(link_trigger[1]));
   err_seen_c: cover property (pslverr);
endmodule : pft_trigger_mapper_chk

bind pft_trigger_mapper pft_trigger_mapper_chk i_chk (.clk, .rst, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .gen_pulse, .link_trigger, .gpo, .front_panel_outputs);

// ### verification/pft_camera_model.sv
`timescale 1ns/1ps
module pft_camera_model
   import pft_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // link trigger channels
   input wire logic [NUM_LINK-1:0] link_trigger,
   // events seen per channel
   output int ev0,
   output int ev1
);
   // one event per cycle a channel is high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ev0 <= 0;
         ev1 <= 0;
      end else begin
         ev0 <= ev0 + int'(link_trigger[0]);
         ev1 <= ev1 + int'(link_trigger[1]);
      end
   end
endmodule : pft_camera_model

// ### verification/pft_trigger_mapper_tb.sv
`timescale 1ns/1ps
module pft_trigger_mapper_tb;
   import pft_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic trig_pulse = 1'b0;
   logic [NUM_GPI-1:0] gpi = '0;
   logic [NUM_FRONT_IN-1:0] front_gpi = '0;
   logic [NUM_GEN-1:0] gen_pulse;
   logic [NUM_LINK-1:0] link_trigger;
   logic [NUM_GPO-1:0] gpo;
   logic [NUM_FRONT_OUT-1:0] front_panel_outputs;
   logic [31:0] rd;
   logic err;
   logic [5:0] seen [NUM_GEN];
   int ev0;
   int ev1;
   int dly;
   int wid;
   int n_fail = 0;
   int tests_run = 0;

   always #10 clk = ~clk;

   pft_trigger_mapper i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .trig_pulse, .gpi, .front_gpi, .gen_pulse, .link_trigger,
      .gpo, .front_panel_outputs);
   pft_camera_model i_cam (.clk, .rst, .link_trigger, .ev0, .ev1);

   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // trigger held hi cycles; gen 0 start and width seen over span cycles
   task automatic shape(input int hi, input int span);
      dly = 0;
      wid = 0;
      @(posedge clk);
      trig_pulse <= 1'b1;
      for (int k = 1; k <= span; k++) begin
         @(posedge clk);
         if (k == hi) trig_pulse <= 1'b0;
         #1;
         if (gen_pulse[0] === 1'b1 && dly == 0) dly = k;
         if (gen_pulse[0] === 1'b1) wid++;
      end
   endtask : shape

   task automatic fire(input int i);
      @(posedge clk);
      trig_pulse <= 1'b1;
      for (int k = 1; k <= 6; k++) begin
         @(posedge clk);
         if (k == 2) trig_pulse <= 1'b0;
         #1;
         for (int g = 0; g < NUM_GEN; g++) if (gen_pulse[g] === 1'b1) seen[g][i] = 1'b1;
      end
   endtask : fire

   task automatic t_regs();
      apb(1'b0, 12'h060, 32'h0);
      chk("ctrl3", 32'h1, rd);
      apb(1'b0, 12'h04C, 32'h0);
      chk("width2", 32'h4E2, rd);
      apb(1'b0, 12'h024, 32'h0);
      chk("delay1", 32'h0, rd);
      apb(1'b0, ADDR_LINK1_SRC, 32'h0);
      chk("link1", 32'h0, rd);
      apb(1'b1, OFF_GEN_CTRL, 32'h70);
      apb(1'b0, OFF_GEN_CTRL, 32'h0);
      chk("clamp", 32'h61, rd);
      apb(1'b1, OFF_GEN_CTRL, 32'h1);
   endtask : t_regs

   task automatic t_shape();
      shape(300, 320);
      chk("start", 1, dly);
      chk("width", 200, wid);
      chk("ev0", 1, ev0);
      chk("ev1", 0, ev1);
      apb(1'b1, OFF_DELAY_LO, 32'd25);
      apb(1'b1, OFF_WIDTH_LO, 32'd50);
      apb(1'b1, ADDR_LINK1_SRC, 32'h5);
      shape(2, 40);
      chk("delay", 5, dly);
      chk("width8", 8, wid);
      chk("ev0b", 2, ev0);
      chk("ev1b", 1, ev1);
   endtask : t_shape

   task automatic t_decim();
      logic [31:0] ctl [NUM_GEN] = '{32'h03, 32'h23, 32'h01, 32'h22};
      repeat (200) @(posedge clk);
      for (int g = 0; g < NUM_GEN; g++) begin
         apb(1'b1, 12'(g * 32) + OFF_WIDTH_LO, 32'h1);
         apb(1'b1, 12'(g * 32) + OFF_GEN_CTRL, ctl[g]);
      end
      apb(1'b1, OFF_DELAY_LO, 32'h0);
      seen = '{default: '0};
      fire(0);
      apb(1'b1, OFF_GEN_CTRL, 32'h3);
      for (int i = 1; i < 6; i++) fire(i);
      chk("gen0", 32'h13, seen[0]);
      chk("gen1", 32'h24, seen[1]);
      chk("gen2", 32'h3F, seen[2]);
      chk("gen3", 32'h0, seen[3]);
   endtask : t_decim

   task automatic t_bypass();
      int e0;
      int e1;
      apb(1'b1, ADDR_LINK0_SRC, 32'd15);
      apb(1'b1, ADDR_LINK1_SRC, 32'd28);
      for (int r = 0; r < 2; r++) begin
         e0 = ev0;
         e1 = ev1;
         @(posedge clk);
         gpi <= 8'h08;
         front_gpi <= 4'h2;
         repeat (10) @(posedge clk);
         gpi <= 8'h00;
         front_gpi <= 4'h0;
         fire(0);
         chk("byp0", e0 + 1 - r, ev0);
         chk("byp1", e1 + 1 - r, ev1);
         apb(1'b1, ADDR_LINK0_SRC, 32'h0);
         apb(1'b1, ADDR_LINK1_SRC, 32'h0);
      end
   endtask : t_bypass

   task automatic t_misc();
      apb(1'b1, ADDR_GPO_OUT, 32'h3A5);
      repeat (2) @(posedge clk);
      chk("gpo", 32'h3A5, {front_panel_outputs, gpo});
      apb(1'b0, 12'h08C, 32'h0);
      chk("unmapped", 32'h1, err);
      chk("errdata", 32'h0, rd);
      apb(1'b0, 12'h002, 32'h0);
      chk("unaligned", 32'h1, err);
      apb(1'b1, OFF_GEN_STAT, 32'hFFFFFFFF);
      chk("statwr", 32'h0, err);
      apb(1'b1, ADDR_LINK0_SRC, 32'd40);
      apb(1'b0, ADDR_LINK0_SRC, 32'h0);
      chk("srcclamp", 32'h0, rd);
   endtask : t_misc

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_shape();
      t_decim();
      t_bypass();
      t_misc();
      print_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
endmodule : pft_trigger_mapper_tb
